//--- sim/ccr_regs_monitor.sv
`timescale 1ns/10ps
`include "ccr_defines.vh"

module ccr_regs_monitor
(
  input logic        mclk,
  input logic        rst_n,
  input logic [7:0]  sfr_addr,
  input logic        sfr_wr,
  input logic [7:0]  sfr_wdata,
  input logic        sfr_rd,
  input logic        bit_wr,
  input logic [2:0]  op_code,
  input logic        push_req,
  input logic [7:0]  push_data,
  input logic        pop_req,
  input logic [7:0]  sfr_rdata,
  input logic        sfr_hit,
  input logic [7:0]  stack_top_pointer,
  input logic [15:0] data_pointer,
  input logic [7:0]  program_status_word,
  input logic [7:0]  primary_accumulator,
  input logic [7:0]  secondary_accumulator,
  input logic [4:0]  reg_bank_base,
  input logic [7:0]  stack_addr,
  input logic        stack_wr_en,
  input logic [7:0]  stack_wr_data,
  input logic        stack_rd_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  a_push_inc: assert property (push_req && !(sfr_wr && sfr_addr == 8'h81) |=>
    stack_top_pointer == $past(stack_top_pointer) + 8'h01) else $error("push count");
  a_push_store: assert property (push_req |=> stack_wr_en &&
    stack_addr == $past(stack_top_pointer) + 8'h01 && stack_wr_data == $past(push_data))
    else $error("push store");
  a_pop_read: assert property (pop_req && !push_req |=> stack_rd_en &&
    stack_addr == $past(stack_top_pointer)) else $error("pop read");
  a_parity_tracks: assert property (program_status_word[0] == ^primary_accumulator)
    else $error("parity");
  a_bank_base: assert property (reg_bank_base == {program_status_word[4:3], 3'b000})
    else $error("bank base");
  a_data_pointer_high: assert property (sfr_wr && sfr_addr == 8'h83 |=>
    data_pointer[15:8] == $past(sfr_wdata)) else $error("pointer high");
  a_acc_read: assert property (sfr_rd && sfr_addr == 8'hE0 |=> sfr_hit &&
    sfr_rdata == $past(primary_accumulator)) else $error("acc read");
  a_unmapped_read: assert property (sfr_rd && sfr_addr == 8'h84 |=>
    !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped read");
  a_div_zero: assert property (op_code == `CCR_OP_DIV && secondary_accumulator == 8'h00
    && !sfr_wr && !bit_wr |=> program_status_word[2] && $stable(primary_accumulator))
    else $error("divide by zero");
  a_user_kept: assert property (op_code != 3'h0 && !sfr_wr && !bit_wr |=>
    $stable({program_status_word[5], program_status_word[1]})) else $error("user flags");
endmodule

bind ccr_regs ccr_regs_monitor i_ccr_regs_monitor (.*);

//--- sim/ccr_regs_tb.sv
`timescale 1ns/10ps

module ccr_regs_tb;
  reg         mclk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wval = 0;
  reg         bit_rd = 0, push_req = 0, pop_req = 0;
  reg  [7:0]  sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, op_operand = 0, push_data = 0;
  reg  [2:0]  op_code = 0, op, f;
  reg  [7:0]  p, a, b, o, ea, eb;
  reg  [53:0] rows [0:8];
  wire [7:0]  sfr_rdata, stack_top_pointer, program_status_word, primary_accumulator;
  wire [7:0]  secondary_accumulator, stack_addr, stack_wr_data;
  wire [15:0] data_pointer;
  wire [4:0]  reg_bank_base;
  wire        sfr_hit, bit_rdata, bit_hit, stack_wr_en, stack_rd_en;
  integer     err_count = 0, checks = 0, i;

  ccr_regs i_ccr_regs (.*);

  initial forever #20 mclk = ~mclk;

  task chk(input [23:0] s, input [23:0] e);
    begin
      checks = checks + 1;
      if (s !== e)
      begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask

  task wr(input [7:0] ad, input [7:0] d);
    begin
      @(negedge mclk) {sfr_addr, sfr_wdata, sfr_wr} = {ad, d, 1'b1};
      @(negedge mclk) sfr_wr = 0;
    end
  endtask

  task rd(input [7:0] ad, input [8:0] e);
    begin
      @(negedge mclk) {sfr_addr, sfr_rd} = {ad, 1'b1};
      @(negedge mclk) sfr_rd = 0;
      chk({sfr_hit, sfr_rdata}, e);
    end
  endtask

  task bw(input [7:0] ad, input v);
    begin
      @(negedge mclk) {bit_addr, bit_wval, bit_wr} = {ad, v, 1'b1};
      @(negedge mclk) bit_wr = 0;
    end
  endtask

  task br(input [7:0] ad, input [1:0] e);
    begin
      @(negedge mclk) {bit_addr, bit_rd} = {ad, 1'b1};
      @(negedge mclk) bit_rd = 0;
      chk({bit_hit, bit_rdata}, e);
    end
  endtask

  task give_verdict;
    begin
      $display("errors=%0d checks=%0d", err_count, checks);
      if (err_count == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // The whole run is about 130 cycles; this cuts a hang short.
  initial
  begin
    #100000;
    err_count = err_count + 1;
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows[0] = {3'h1, 8'h22, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h00, 3'b011};
    rows[1] = {3'h1, 8'h3A, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 3'b110};
    rows[2] = {3'h2, 8'hBA, 8'h0E, 8'h00, 8'h01, 8'h10, 8'h00, 3'b010};
    rows[3] = {3'h3, 8'h02, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 3'b110};
    rows[4] = {3'h3, 8'hA0, 8'h80, 8'h00, 8'h00, 8'h7F, 8'h00, 3'b011};
    rows[5] = {3'h4, 8'h22, 8'h10, 8'h10, 8'h00, 8'h00, 8'h01, 3'b001};
    rows[6] = {3'h4, 8'hC2, 8'h0F, 8'h11, 8'h00, 8'hFF, 8'h00, 3'b000};
    rows[7] = {3'h5, 8'h22, 8'hFF, 8'h10, 8'h00, 8'h0F, 8'h0F, 3'b000};
    rows[8] = {3'h5, 8'h22, 8'h55, 8'h00, 8'h00, 8'h55, 8'h00, 3'b001};
    repeat (6) @(negedge mclk);
    rst_n = 1;
    for (i = 0; i < 9; i = i + 1)
    begin
      {op, p, a, b, o, ea, eb, f} = rows[i];
      wr(8'hD0, p);
      wr(8'hE0, a);
      wr(8'hF0, b);
      @(negedge mclk) {op_code, op_operand} = {op, o};
      @(negedge mclk) op_code = 0;
      chk(primary_accumulator, ea);
      chk(secondary_accumulator, eb);
      chk(program_status_word, {f[2:1], p[5:3], f[0], p[1], ^ea});
    end
    // Reset in mid-run must bring back every reset value.
    rst_n = 0;
    repeat (2) @(negedge mclk);
    rst_n = 1;
    rd(8'h81, 9'h107);
    rd(8'h82, 9'h100);
    rd(8'h83, 9'h100);
    rd(8'hD0, 9'h100);
    rd(8'hE0, 9'h100);
    rd(8'hF0, 9'h100);
    wr(8'h84, 8'h5A);
    rd(8'h84, 9'h000);
    @(negedge mclk) {push_req, push_data} = {1'b1, 8'hAA};
    @(negedge mclk) push_data = 8'h55;
    chk({stack_wr_en, stack_addr, stack_wr_data}, {1'b1, 8'h08, 8'hAA});
    @(negedge mclk) push_req = 0;
    chk({stack_wr_en, stack_addr, stack_top_pointer}, {1'b1, 8'h09, 8'h09});
    chk(stack_wr_data, 8'h55);
    @(negedge mclk) pop_req = 1;
    @(negedge mclk) pop_req = 0;
    chk({stack_rd_en, stack_addr, stack_top_pointer}, {1'b1, 8'h09, 8'h08});
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    chk(data_pointer, 16'h1234);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'hD0, {3'b000, i[1:0], 3'b000});
      chk(reg_bank_base, {i[1:0], 3'b000});
    end
    bw(8'hD5, 1'b1);
    bw(8'hD0, 1'b1);
    chk(program_status_word, 8'h38);
    br(8'hD5, 2'b11);
    br(8'h81, 2'b00);
    bw(8'hE7, 1'b1);
    chk(program_status_word, 8'h39);
    bw(8'hF0, 1'b1);
    br(8'hF0, 2'b11);
    wr(8'hD0, 8'h00);
    chk(program_status_word, 8'h01);
    give_verdict;
  end
endmodule

//--- verilog/ccr_arith.v
`timescale 1ns/10ps
`include "ccr_defines.vh"

module ccr_arith
(
  input  wire [2:0] op_code,
  input  wire [7:0] acc,
  input  wire [7:0] bval,
  input  wire [7:0] opnd,
  input  wire       cin,
  output reg  [7:0] res_a,
  output reg  [7:0] res_b,
  output reg        cy,
  output reg        ac,
  output reg        ov
);

  wire        carry = (op_code == `CCR_OP_ADD) ? 1'b0 : cin;
  wire [8:0]  sum9  = {1'b0, acc} + {1'b0, opnd} + {8'h00, carry};
  wire [4:0]  sum5  = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, carry};
  wire [8:0]  dif9  = {1'b0, acc} - {1'b0, opnd} - {8'h00, carry};
  wire [4:0]  dif5  = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, carry};
  wire [15:0] prod  = {8'h00, acc} * {8'h00, bval};
  wire        dzero = (bval == 8'h00);
  wire [7:0]  quot  = dzero ? acc : acc / bval;
  wire [7:0]  rem   = dzero ? bval : acc % bval;

  always @*
  begin
    res_a = acc;
    res_b = bval;
    cy    = 1'b0;
    ac    = 1'b0;
    ov    = 1'b0;
    case (op_code)
      `CCR_OP_ADD, `CCR_OP_ADDC:
      begin
        res_a = sum9[7:0];
        cy    = sum9[8];
        ac    = sum5[4];
        ov    = (acc[7] == opnd[7]) && (sum9[7] != acc[7]);
      end
      `CCR_OP_SUBB:
      begin
        res_a = dif9[7:0];
        cy    = dif9[8];
        ac    = dif5[4];
        ov    = (acc[7] != opnd[7]) && (dif9[7] != acc[7]);
      end
      `CCR_OP_MUL:
      begin
        res_a = prod[7:0];
        res_b = prod[15:8];
        ov    = (prod[15:8] != 8'h00);
      end
      `CCR_OP_DIV:
      begin
        res_a = quot;
        res_b = rem;
        ov    = dzero;
      end
      default:
      begin
        res_a = acc;
      end
    endcase
  end

endmodule

//--- verilog/ccr_bit_mod.v
`timescale 1ns/10ps

module ccr_bit_mod
(
  input  wire [7:0] din,
  input  wire [2:0] idx,
  input  wire       val,
  output wire [7:0] dout,
  output wire       bit_out
);

  genvar i;

  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      localparam [2:0] BIT_IDX = i;
      assign dout[i] = (idx == BIT_IDX) ? val : din[i];
    end
  endgenerate

  assign bit_out = din[idx];

endmodule

//--- verilog/ccr_defines.vh
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Direct addresses of the core registers.
`define CCR_ADDR_SP        8'h81
`define CCR_ADDR_DPL       8'h82
`define CCR_ADDR_DPH       8'h83
`define CCR_ADDR_PSW       8'hD0
`define CCR_ADDR_ACC       8'hE0
`define CCR_ADDR_B         8'hF0

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define CCR_RST_SP         8'h07
`define CCR_RST_DPL        8'h00
`define CCR_RST_DPH        8'h00
`define CCR_RST_PSW        8'h00
`define CCR_RST_ACC        8'h00
`define CCR_RST_B          8'h00

////////////////////////////////////////////////////////////////////////////////
// Status word bit positions.
`define CCR_PSW_CY         7
`define CCR_PSW_AC         6
`define CCR_PSW_F0         5
`define CCR_PSW_RS1        4
`define CCR_PSW_RS0        3
`define CCR_PSW_OV         2
`define CCR_PSW_F1         1
`define CCR_PSW_PAR        0

////////////////////////////////////////////////////////////////////////////////
// Arithmetic operation codes.
`define CCR_OP_NONE        3'h0
`define CCR_OP_ADD         3'h1
`define CCR_OP_ADDC        3'h2
`define CCR_OP_SUBB        3'h3
`define CCR_OP_MUL         3'h4
`define CCR_OP_DIV         3'h5

`endif

//--- verilog/ccr_regs.v
// Operation
// - Pointer bytes form sixteen-bit data pointer.
// - Push increments pointer, then stores data.
// - Stack pointer resets to seven.
// - Carry from add carry or subtract borrow.
// - Nibble carry from low-nibble carry, borrow.
// - Two user flags belong to software.
// - Bank bits pick one of four banks.
// - Signed overflow on add and subtract.
// - Overflow when product exceeds 255.
// - Overflow on divide by zero.
// - Arithmetic ops clear overflow otherwise.
// - Parity is read-only accumulator odd parity.
// - Accumulator is primary operand and result.
// - Second accumulator serves multiply, divide.
// - High direct addresses reach registers; bit access.

`timescale 1ns/10ps
`include "ccr_defines.vh"

module ccr_regs
(
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_rd,
  input  wire [7:0]  bit_addr,
  input  wire        bit_wr,
  input  wire        bit_wval,
  input  wire        bit_rd,
  input  wire [2:0]  op_code,
  input  wire [7:0]  op_operand,
  input  wire        push_req,
  input  wire [7:0]  push_data,
  input  wire        pop_req,
  output reg  [7:0]  sfr_rdata,
  output reg         sfr_hit,
  output reg         bit_rdata,
  output reg         bit_hit,
  output reg  [7:0]  stack_top_pointer,
  output wire [15:0] data_pointer,
  output reg  [7:0]  program_status_word,
  output reg  [7:0]  primary_accumulator,
  output reg  [7:0]  secondary_accumulator,
  output wire [4:0]  reg_bank_base,
  output reg  [7:0]  stack_addr,
  output reg         stack_wr_en,
  output reg  [7:0]  stack_wr_data,
  output reg         stack_rd_en
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and next values.

  reg  [7:0] data_pointer_low;
  reg  [7:0] data_pointer_high;
  reg  [7:0] next_sp;
  reg  [7:0] next_dpl;
  reg  [7:0] next_dph;
  reg  [7:0] next_psw;
  reg  [7:0] next_acc;
  reg  [7:0] next_b;
  reg  [7:0] next_rdata;
  reg        next_hit;
  reg        next_bit;
  reg        next_bit_hit;
  reg  [7:0] next_stack_addr;
  reg        next_stack_wr;
  reg        next_stack_rd;

  wire [7:0] alu_a;
  wire [7:0] alu_b;
  wire       alu_cy;
  wire       alu_ac;
  wire       alu_ov;
  wire       op_active;
  wire [7:0] bit_byte;
  wire [7:0] psw_bitw;
  wire [7:0] acc_bitw;
  wire [7:0] b_bitw;
  wire       psw_bitr;
  wire       acc_bitr;
  wire       b_bitr;

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic and bit access helpers.

  ccr_arith u_arith
  (
    .op_code (op_code),
    .acc     (primary_accumulator),
    .bval    (secondary_accumulator),
    .opnd    (op_operand),
    .cin     (program_status_word[`CCR_PSW_CY]),
    .res_a   (alu_a),
    .res_b   (alu_b),
    .cy      (alu_cy),
    .ac      (alu_ac),
    .ov      (alu_ov)
  );

  assign op_active = (op_code != `CCR_OP_NONE);

  assign bit_byte = {bit_addr[7:3], 3'b000};

  ccr_bit_mod u_bit_psw
  (
    .din     (program_status_word),
    .idx     (bit_addr[2:0]),
    .val     (bit_wval),
    .dout    (psw_bitw),
    .bit_out (psw_bitr)
  );

  ccr_bit_mod u_bit_acc
  (
    .din     (primary_accumulator),
    .idx     (bit_addr[2:0]),
    .val     (bit_wval),
    .dout    (acc_bitw),
    .bit_out (acc_bitr)
  );

  ccr_bit_mod u_bit_b
  (
    .din     (secondary_accumulator),
    .idx     (bit_addr[2:0]),
    .val     (bit_wval),
    .dout    (b_bitw),
    .bit_out (b_bitr)
  );

  assign data_pointer = {data_pointer_high, data_pointer_low};

  assign reg_bank_base = {program_status_word[`CCR_PSW_RS1],
                          program_status_word[`CCR_PSW_RS0], 3'b000};

  ////////////////////////////////////////////////////////////////////////////////
  // Stack pointer and stack strobes.
  // A push and a pop in one cycle is resolved as the push alone; a byte
  // write to the stack pointer in that cycle overrides the adjustment.

  always @*
  begin
    next_sp         = stack_top_pointer;
    next_stack_addr = stack_addr;
    next_stack_wr   = 1'b0;
    next_stack_rd   = 1'b0;
    if (push_req)
    begin
      next_sp         = stack_top_pointer + 8'h01;
      next_stack_addr = stack_top_pointer + 8'h01;
      next_stack_wr   = 1'b1;
    end
    else if (pop_req)
    begin
      next_sp         = stack_top_pointer - 8'h01;
      next_stack_addr = stack_top_pointer;
      next_stack_rd   = 1'b1;
    end
    if (sfr_wr && (sfr_addr == `CCR_ADDR_SP))
    begin
      next_sp = sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data pointer bytes.

  always @*
  begin
    next_dpl = data_pointer_low;
    next_dph = data_pointer_high;
    if (sfr_wr && (sfr_addr == `CCR_ADDR_DPL))
    begin
      next_dpl = sfr_wdata;
    end
    if (sfr_wr && (sfr_addr == `CCR_ADDR_DPH))
    begin
      next_dph = sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Accumulators. Software writes land after the operation result, so a
  // write in the same cycle as an operation wins on that register.

  always @*
  begin
    next_acc = primary_accumulator;
    next_b   = secondary_accumulator;
    if (op_active)
    begin
      next_acc = alu_a;
      if ((op_code == `CCR_OP_MUL) || (op_code == `CCR_OP_DIV))
      begin
        next_b = alu_b;
      end
    end
    if (sfr_wr && (sfr_addr == `CCR_ADDR_ACC))
    begin
      next_acc = sfr_wdata;
    end
    if (sfr_wr && (sfr_addr == `CCR_ADDR_B))
    begin
      next_b = sfr_wdata;
    end
    if (bit_wr && bit_addr[7] && (bit_byte == `CCR_ADDR_ACC))
    begin
      next_acc = acc_bitw;
    end
    if (bit_wr && bit_addr[7] && (bit_byte == `CCR_ADDR_B))
    begin
      next_b = b_bitw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status word. The parity bit is rebuilt every cycle from the accumulator
  // value being loaded, so it never lags the accumulator by a cycle.

  always @*
  begin
    next_psw = program_status_word;
    if (op_active)
    begin
      next_psw[`CCR_PSW_CY] = alu_cy;
      next_psw[`CCR_PSW_AC] = alu_ac;
      next_psw[`CCR_PSW_OV] = alu_ov;
    end
    if (sfr_wr && (sfr_addr == `CCR_ADDR_PSW))
    begin
      next_psw = sfr_wdata;
    end
    if (bit_wr && bit_addr[7] && (bit_byte == `CCR_ADDR_PSW))
    begin
      next_psw = psw_bitw;
    end
    next_psw[`CCR_PSW_PAR] = ^next_acc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read paths. Data appears on the edge after the request and reflects the
  // registers before any write taken on that same edge.

  always @*
  begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    if (sfr_rd)
    begin
      next_hit = 1'b1;
      case (sfr_addr)
        `CCR_ADDR_SP:  next_rdata = stack_top_pointer;
        `CCR_ADDR_DPL: next_rdata = data_pointer_low;
        `CCR_ADDR_DPH: next_rdata = data_pointer_high;
        `CCR_ADDR_PSW: next_rdata = program_status_word;
        `CCR_ADDR_ACC: next_rdata = primary_accumulator;
        `CCR_ADDR_B:   next_rdata = secondary_accumulator;
        default:
        begin
          next_rdata = 8'h00;
          next_hit   = 1'b0;
        end
      endcase
    end
  end

  always @*
  begin
    next_bit     = 1'b0;
    next_bit_hit = 1'b0;
    if (bit_rd && bit_addr[7])
    begin
      next_bit_hit = 1'b1;
      case (bit_byte)
        `CCR_ADDR_PSW: next_bit = psw_bitr;
        `CCR_ADDR_ACC: next_bit = acc_bitr;
        `CCR_ADDR_B:   next_bit = b_bitr;
        default:
        begin
          next_bit     = 1'b0;
          next_bit_hit = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers.

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_top_pointer     <= `CCR_RST_SP;
      data_pointer_low      <= `CCR_RST_DPL;
      data_pointer_high     <= `CCR_RST_DPH;
      program_status_word   <= `CCR_RST_PSW;
      primary_accumulator   <= `CCR_RST_ACC;
      secondary_accumulator <= `CCR_RST_B;
      sfr_rdata             <= 8'h00;
      sfr_hit               <= 1'b0;
      bit_rdata             <= 1'b0;
      bit_hit               <= 1'b0;
      stack_addr            <= 8'h00;
      stack_wr_en           <= 1'b0;
      stack_wr_data         <= 8'h00;
      stack_rd_en           <= 1'b0;
    end
    else
    begin
      stack_top_pointer     <= next_sp;
      data_pointer_low      <= next_dpl;
      data_pointer_high     <= next_dph;
      program_status_word   <= next_psw;
      primary_accumulator   <= next_acc;
      secondary_accumulator <= next_b;
      sfr_rdata             <= next_rdata;
      sfr_hit               <= next_hit;
      bit_rdata             <= next_bit;
      bit_hit               <= next_bit_hit;
      stack_addr            <= next_stack_addr;
      stack_wr_en           <= next_stack_wr;
      stack_rd_en           <= next_stack_rd;
      if (push_req)
      begin
        stack_wr_data <= push_data;
      end
    end
  end

endmodule
